// ===== verilog/dither_correction_sequencer.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dither_correction_sequencer
   import dither_seq_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Static pins and comparators, asynchronous
   input wire logic ratio_sel_b2,
   input wire logic ratio_sel_b1,
   input wire logic ratio_sel_b0,
   input wire logic spread_en,
   input wire logic excess_output_inhibit,
   input wire logic run_ok,
   // Loop and hold controls
   output logic regulate_out,
   output logic current_loop_en,
   output hold_ctrl_s hold_ctrl,
   output logic correction_apply,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int SYNC_W = 6;

   // Pin synchronisers
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= {ratio_sel_b2, ratio_sel_b1, ratio_sel_b0,
                    spread_en, excess_output_inhibit, run_ok};
         sync_b <= sync_a;
      end
   end

   wire logic [RATIO_SEL_W-1:0] ratio_code = sync_b[5:3];
   wire logic spread_s = sync_b[2];
   wire logic inhibit_s = sync_b[1];
   wire logic run_s = sync_b[0];

   // Software control
   logic [1:0] ctrl;
   logic [31:0] cycle_count;

   wire logic running = run_s && ctrl[CTRL_ENABLE_BIT];
   wire logic spread_on = spread_s && !ctrl[CTRL_FIXED_PHASE_BIT];

   // Dither timing
   logic [SLOT_W-1:0] slot_idx;
   logic cycle_end;
   logic [LFSR_W-1:0] lfsr_value;

   slot_divider u_slot_divider (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(running),
      .ratio_code(ratio_code),
      .spread(spread_on),
      .offset(lfsr_value),
      .slot_idx(slot_idx),
      .cycle_end(cycle_end)
   );

   // Stepped in fixed mode too, so enabling spread never starts from seed
   phase_lfsr u_phase_lfsr (
      .aclk(aclk),
      .aresetn(aresetn),
      .step(cycle_end),
      .value(lfsr_value)
   );

   // Slot to phase decode
   wire logic in_regulate = slot_idx < SLOT_TRACK_HIGH;
   wire logic in_track_high = !in_regulate && slot_idx < SLOT_CURRENT_STEP;
   wire logic in_step = slot_idx >= SLOT_CURRENT_STEP
                        && slot_idx < SLOT_TRACK_LOW;
   wire logic in_track_low = slot_idx >= SLOT_TRACK_LOW
                             && slot_idx < SLOT_TRANSFER;

   phase_e next_phase;

   always_comb begin
      if (!running) begin
         next_phase = PH_IDLE;
      end else if (in_regulate) begin
         next_phase = PH_REGULATE;
      end else if (in_track_high) begin
         next_phase = PH_TRACK_HIGH;
      end else if (in_step) begin
         next_phase = PH_CURRENT_STEP;
      end else if (in_track_low) begin
         next_phase = PH_TRACK_LOW;
      end else begin
         next_phase = PH_TRANSFER;
      end
   end

   phase_e phase;
   logic delta_valid;
   hold_ctrl_s next_hold;
   logic next_regulate;
   logic next_current;

   always_comb begin
      next_hold = '0;
      next_regulate = 1'b1;
      next_current = 1'b0;
      case (next_phase)
         PH_IDLE: begin
            next_regulate = 1'b1;
         end
         PH_REGULATE: begin
            next_hold.hold_cap_1 = 1'b1;
            next_hold.hold_cap_2 = 1'b1;
         end
         PH_TRACK_HIGH: begin
            next_hold.hold_cap_2 = 1'b1;
         end
         PH_CURRENT_STEP: begin
            next_regulate = 1'b0;
            next_current = 1'b1;
            next_hold.hold_cap_3 = 1'b1;
         end
         PH_TRACK_LOW: begin
            next_regulate = 1'b0;
            next_current = 1'b1;
            next_hold.hold_cap_3 = 1'b1;
         end
         PH_TRANSFER: begin
            next_hold.hold_cap_4 = 1'b1;
         end
         default: begin
            next_regulate = 1'b1;
         end
      endcase
   end

   // A delta exists only after a full transfer phase has completed
   wire logic transfer_done = phase == PH_TRANSFER
                              && next_phase != PH_TRANSFER;
   wire logic next_valid = running && (delta_valid || transfer_done);
   wire logic next_apply = next_valid && !inhibit_s;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase <= PH_IDLE;
         hold_ctrl <= '0;
         regulate_out <= 1'b1;
         current_loop_en <= 1'b0;
         delta_valid <= 1'b0;
         correction_apply <= 1'b0;
      end else begin
         phase <= next_phase;
         hold_ctrl <= next_hold;
         regulate_out <= next_regulate;
         current_loop_en <= next_current;
         delta_valid <= next_valid;
         correction_apply <= next_apply && ctrl[CTRL_ENABLE_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cycle_count <= '0;
      end else if (cycle_end) begin
         cycle_count <= cycle_count + 32'h0000_0001;
      end
   end

   // One decode for both channels keeps reads and writes in agreement
   function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
      reg_mapped = addr == REG_CTRL || addr == REG_STATUS
                   || addr == REG_CYCLES;
   endfunction : reg_mapped

   // AXI4-Lite slave
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;

   wire logic aw_hs = s_axi_awvalid && s_axi_awready;
   wire logic w_hs = s_axi_wvalid && s_axi_wready;
   wire logic wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire logic wr_ctrl = wr_addr == REG_CTRL;
   wire logic wr_ok = reg_mapped(wr_addr);
   wire logic b_hs = s_axi_bvalid && s_axi_bready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
      end else begin
         if (aw_hs) begin
            s_axi_awready <= 1'b0;
            wr_addr <= s_axi_awaddr;
         end
         if (w_hs) begin
            s_axi_wready <= 1'b0;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (b_hs) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Status and cycle count are read only; writes to them are ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RESET;
      end else if (wr_fire && wr_ctrl && wr_strb[0]) begin
         ctrl <= wr_data[1:0];
      end
   end

   wire logic [31:0] status_word = {8'h00, CURRENT_STEP_PCT,
                                    5'h00, ratio_code,
                                    1'b0, SLOT_W'(phase),
                                    correction_apply, delta_valid,
                                    inhibit_s, run_s};

   wire logic [31:0] read_word =
      s_axi_araddr == REG_CTRL ? {30'h0000_0000, ctrl} :
      s_axi_araddr == REG_STATUS ? status_word :
      s_axi_araddr == REG_CYCLES ? cycle_count : 32'h0000_0000;
   wire logic rd_ok = reg_mapped(s_axi_araddr);
   wire logic ar_hs = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= read_word;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : dither_correction_sequencer

// ===== verilog/dither_seq_pkg.sv
package dither_seq_pkg;

   // Dither ratio select and slot timing
   localparam int RATIO_SEL_W = 3;
   localparam int SLOT_W = 3;
   localparam int PRE_W = 8;
   localparam logic [RATIO_SEL_W-1:0] RATIO_CODE_128 = 3'h4;
   localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h7;
   localparam logic [SLOT_W-1:0] SLOT_TRACK_HIGH = 3'h2;
   localparam logic [SLOT_W-1:0] SLOT_CURRENT_STEP = 3'h3;
   localparam logic [SLOT_W-1:0] SLOT_TRACK_LOW = 3'h5;
   localparam logic [SLOT_W-1:0] SLOT_TRANSFER = 3'h6;

   // Current step of the modulation, in percent of the sampled current
   localparam logic [7:0] CURRENT_STEP_PCT = 8'h5a;

   // Pseudo-random phasing generator
   localparam int LFSR_W = 8;
   localparam logic [LFSR_W-1:0] LFSR_TAPS = 8'hb8;
   localparam logic [LFSR_W-1:0] LFSR_SEED = 8'h01;

   // Register map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_CYCLES = 8'h08;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_FIXED_PHASE_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {
      PH_IDLE,
      PH_REGULATE,
      PH_TRACK_HIGH,
      PH_CURRENT_STEP,
      PH_TRACK_LOW,
      PH_TRANSFER
   } phase_e;

   // Track controls: high tracks, low holds
   typedef struct packed {
      logic hold_cap_1;
      logic hold_cap_2;
      logic hold_cap_3;
      logic hold_cap_4;
   } hold_ctrl_s;

   // Clocks per slot: one eighth of the division ratio
   function automatic logic [PRE_W-1:0] slot_len(
      input logic [RATIO_SEL_W-1:0] code);
      slot_len = 8'h01 << code;
   endfunction : slot_len

endpackage : dither_seq_pkg

// ===== verilog/phase_lfsr.sv
`timescale 1ns/1ps
module phase_lfsr
   import dither_seq_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Step once per dither cycle
   input wire logic step,
   output logic [LFSR_W-1:0] value
);

   wire logic feedback = ^(value & LFSR_TAPS);

   // Seeded non-zero and advanced only on step, so the sequence never locks up at zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         value <= LFSR_SEED;
      end else if (step) begin
         value <= {value[LFSR_W-2:0], feedback};
      end
   end

endmodule : phase_lfsr

// ===== verilog/slot_divider.sv
`timescale 1ns/1ps
module slot_divider
   import dither_seq_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic run,
   input wire logic [RATIO_SEL_W-1:0] ratio_code,
   input wire logic spread,
   input wire logic [LFSR_W-1:0] offset,
   // Timing
   output logic [SLOT_W-1:0] slot_idx,
   output logic cycle_end
);

   logic [PRE_W-1:0] pre;
   wire logic [PRE_W-1:0] len_m1 = slot_len(ratio_code) - 8'h01;
   wire logic slot_end = run && (pre == len_m1);
   wire logic wrap = slot_end && (slot_idx == SLOT_LAST);

   // Eight slots of ratio/8 clocks make one dither period; with spread, slot 0 is cut short by the offset
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         pre <= '0;
         slot_idx <= '0;
         cycle_end <= 1'b0;
      end else begin
         cycle_end <= wrap;
         if (wrap && spread) begin
            pre <= offset[PRE_W-1:0] & len_m1;
         end else if (slot_end) begin
            pre <= '0;
         end else begin
            pre <= pre + 8'h01;
         end
         if (slot_end) begin
            slot_idx <= slot_idx + 3'h1;
         end
      end
   end

endmodule : slot_divider

// ===== testbench/dither_seq_chk.sv
`timescale 1ns/1ps
module dither_seq_chk
   import dither_seq_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pins
   input wire logic ratio_sel_b2,
   input wire logic ratio_sel_b1,
   input wire logic ratio_sel_b0,
   input wire logic spread_en,
   input wire logic excess_output_inhibit,
   input wire logic run_ok,
   // Controls
   input wire logic regulate_out,
   input wire logic current_loop_en,
   input wire hold_ctrl_s hold_ctrl,
   input wire logic correction_apply
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [10:0] cnt;
   logic [1:0] good;
   logic [2:0] code_q;
   logic c4_q;
   wire [2:0] code = {ratio_sel_b2, ratio_sel_b1, ratio_sel_b0};
   wire rise4 = hold_ctrl.hold_cap_4 && !c4_q;
   wire calm = aresetn && code == code_q && !spread_en && run_ok;
   // Only periods well after the synced code settles are judged
   always_ff @(posedge aclk) begin
      c4_q <= hold_ctrl.hold_cap_4;
      code_q <= code;
      cnt <= (rise4 || !calm) ? 11'h001 : cnt + 11'h001;
      if (!calm)
         good <= 2'h0;
      else if (rise4 && good != 2'h3)
         good <= good + 2'h1;
   end
   sequence s_step;
      current_loop_en ##1 !current_loop_en;
   endsequence
   period_len_a: assert property (rise4 && good == 2'h3 |->
      cnt == (11'h008 << code_q)) else $error("dither period wrong");
   step_opens_a: assert property (current_loop_en |-> !regulate_out)
      else $error("voltage loop closed in step");
   step_holds_a: assert property (current_loop_en |->
      !hold_ctrl.hold_cap_1 && !hold_ctrl.hold_cap_2) else $error("no hold");
   low_capture_a: assert property (hold_ctrl.hold_cap_3 |->
      current_loop_en) else $error("low stage tracks outside step");
   transfer_reg_a: assert property (hold_ctrl.hold_cap_4 |->
      regulate_out && !hold_ctrl.hold_cap_3) else $error("bad transfer");
   inhibit_stop_a: assert property (excess_output_inhibit [*8] |->
      !correction_apply) else $error("correction while inhibited");
   run_gate_a: assert property (!run_ok [*5] |->
      !current_loop_en && hold_ctrl == 4'h0) else $error("runs without run");
   track_first_a: assert property ($rose(current_loop_en) |->
      $past(hold_ctrl.hold_cap_2) && !$past(hold_ctrl.hold_cap_1))
      else $error("step without held control point");
   step_order_a: assert property (s_step |->
      hold_ctrl.hold_cap_4 || hold_ctrl == 4'h0) else $error("bad order");
endmodule : dither_seq_chk

bind dither_correction_sequencer dither_seq_chk u_chk(.aclk, .aresetn,
   .ratio_sel_b2, .ratio_sel_b1, .ratio_sel_b0, .spread_en,
   .excess_output_inhibit, .run_ok, .regulate_out, .current_loop_en,
   .hold_ctrl, .correction_apply);

// ===== testbench/supply_model.sv
`timescale 1ns/1ps
module supply_model #(
   parameter int START_DLY = 12
) (
   // Clock
   input wire logic aclk,
   // Bench commands
   input wire logic cmd_run,
   input wire logic cmd_ov,
   // Comparator levels
   output logic run_ok,
   output logic excess_output_inhibit
);
   int ramp = 0;
   // Input rail ramps before the run comparator trips
   always @(posedge aclk) begin
      ramp <= cmd_run ? ((ramp < START_DLY) ? ramp + 1 : ramp) : 0;
      run_ok <= cmd_run && ramp == START_DLY;
      excess_output_inhibit <= cmd_ov;
   end
endmodule : supply_model

// ===== testbench/dither_correction_sequencer_tb.sv
`timescale 1ns/1ps
module dither_correction_sequencer_tb;
   import dither_seq_pkg::*;
   logic aclk = 0, aresetn = 0, spread_en = 0, cmd_run = 0, cmd_ov = 0;
   logic [2:0] code = 3'h0;
   logic run_ok, excess_output_inhibit, regulate_out, current_loop_en;
   logic correction_apply, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, c4_q = 0;
   hold_ctrl_s hold_ctrl;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [34:0] exp_q[$];
   logic [34:0] e;
   int per_q[$];
   int n_mismatch = 0, compares = 0, last_per = 0, cnt = 0, n;
   logic have_prev = 0;
   logic [15:0] rnd = 16'h4bf6;
   initial forever #2.5 aclk = ~aclk;
   supply_model u_sup(.aclk, .cmd_run, .cmd_ov, .run_ok,
      .excess_output_inhibit);
   dither_correction_sequencer u_dut(.aclk, .aresetn,
      .ratio_sel_b2(code[2]), .ratio_sel_b1(code[1]),
      .ratio_sel_b0(code[0]), .spread_en, .excess_output_inhibit, .run_ok,
      .regulate_out, .current_loop_en, .hold_ctrl, .correction_apply,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("ERROR %0t: %s", $time, msg);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      logic done;
      done = 0;
      exp_q.push_back({1'b1, r, 32'h0000_0000});
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) begin
            check(!s_axi_awvalid && !s_axi_wvalid, "early response");
            s_axi_bready <= 0;
            done = 1;
         end
      end
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      logic done;
      done = 0;
      exp_q.push_back({1'b0, r, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) begin
            check(!s_axi_arvalid, "early read data");
            s_axi_rready <= 0;
            done = 1;
         end
      end
   endtask : axr
   // Monitor: bus answers and transfer-to-transfer spacing
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) begin
         e = exp_q.pop_front();
         check(e[34] ? s_axi_bresp === e[33:32] :
            {s_axi_rresp, s_axi_rdata} === e[33:0], "bus answer");
      end
      if (hold_ctrl.hold_cap_4 && !c4_q) begin
         if (have_prev && per_q.size() > 0)
            check(cnt === per_q.pop_front(), "dither period");
         last_per = cnt;
         have_prev = 1;
         cnt = 1;
      end else
         cnt++;
      c4_q = hold_ctrl.hold_cap_4;
   end
   initial begin
      #(40000 * 5);
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      repeat (40) @(posedge aclk);
      check(!current_loop_en && hold_ctrl === 4'h0, "idle");
      $display("test idle done");
      axr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
      rnd = lfsr(rnd);
      axw(REG_CTRL, {rnd, 16'h0001}, RESP_OKAY);
      axr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
      axw(REG_CYCLES, {16'h0000, rnd}, RESP_OKAY);
      axw(8'h0c, 32'h0000_0001, RESP_SLVERR);
      axr(8'h0c, 32'h0000_0000, RESP_SLVERR);
      axr(REG_STATUS, {8'h00, CURRENT_STEP_PCT, 16'h0000}, RESP_OKAY);
      axr(REG_CYCLES, 32'h0000_0000, RESP_OKAY);
      $display("test regs done");
      cmd_run <= 1;
      repeat (60) @(posedge aclk);
      check(correction_apply === 1'b1, "no correction");
      cmd_ov <= 1;
      repeat (8) @(posedge aclk);
      check(correction_apply === 1'b0, "correction inhibited");
      cmd_ov <= 0;
      $display("test inhibit done");
      for (int k = 0; k < 8; k++) begin
         code <= k[2:0];
         repeat ((16 << k) + 20) @(posedge aclk);
         per_q.push_back(8 << k);
         while (per_q.size() > 0) @(posedge aclk);
      end
      $display("test ratio done");
      spread_en <= 1;
      repeat (2100) @(posedge aclk);
      n = 0;
      repeat (6) begin
         @(posedge hold_ctrl.hold_cap_4);
         @(posedge aclk);
         #1;
         if (last_per != 1024) n++;
      end
      check(n > 0, "no phase spread");
      axw(REG_CTRL, 32'h0000_0003, RESP_OKAY);
      repeat (2100) @(posedge aclk);
      per_q.push_back(1024);
      while (per_q.size() > 0) @(posedge aclk);
      axr(REG_CTRL, 32'h0000_0003, RESP_OKAY);
      axw(REG_CTRL, 32'h0000_0000, RESP_OKAY);
      repeat (4) @(posedge aclk);
      check(hold_ctrl === 4'h0 && !current_loop_en, "off");
      check(correction_apply === 1'b0, "correction off");
      axr(REG_STATUS, {8'h00, CURRENT_STEP_PCT, 16'h0701}, RESP_OKAY);
      axw(REG_CTRL, 32'h0000_0001, RESP_OKAY);
      spread_en <= 0;
      cmd_run <= 0;
      repeat (10) @(posedge aclk);
      check(!current_loop_en && regulate_out === 1'b1, "stop");
      $display("test spread done");
      tally_and_finish;
   end
endmodule : dither_correction_sequencer_tb
